// >>> rtl/cwd_defines.vh
// Constants shared by the configuration word decoder files.
`ifndef CWD_DEFINES_VH
`define CWD_DEFINES_VH

// ==========================================================================
// Register map (byte addresses on the AXI4-Lite bus)
// ==========================================================================
`define CWD_ADDR_CONFIG 4'h0
`define CWD_ADDR_STATUS 4'h4
`define CWD_ADDR_BITS 4

// ==========================================================================
// Configuration word layout and reset value
// ==========================================================================
`define CWD_CFG_RESET 16'hffff
`define CWD_BIT_MODE2 15
`define CWD_BIT_MODE1 6
`define CWD_BIT_MODE0 4
`define CWD_BIT_ZERO_HI 7
`define CWD_BIT_ZERO_LO 5
`define CWD_PS_HI 3
`define CWD_PS_LO 2
`define CWD_OSC_HI 1
`define CWD_OSC_LO 0
`define CWD_UNIMPL_ONES 16'h7e00

// ==========================================================================
// Field encodings
// ==========================================================================
`define CWD_MODE_CPU 3'h7
`define CWD_MODE_MCU 3'h6
`define CWD_MODE_EXT 3'h5
`define CWD_MODE_PROT 3'h0
`define CWD_PS_DIV1 2'h3
`define CWD_PS_DIV256 2'h2
`define CWD_PS_DIV64 2'h1
`define CWD_PS_OFF 2'h0
`define CWD_OSC_EXT 2'h3
`define CWD_OSC_XTAL 2'h2
`define CWD_OSC_RC 2'h1
`define CWD_OSC_LF 2'h0
`define CWD_DIV_ONE 9'h001
`define CWD_DIV_64 9'h040
`define CWD_DIV_256 9'h100
`define CWD_DIV_NONE 9'h000

// ==========================================================================
// Status register field positions
// ==========================================================================
`define CWD_ST_MODE_LO 0
`define CWD_ST_PROT 3
`define CWD_ST_WDT_EN 4
`define CWD_ST_TMR16 5
`define CWD_ST_OSC_LO 6
`define CWD_ST_DIV_LO 16

// ==========================================================================
// Bus responses
// ==========================================================================
`define CWD_RESP_OKAY 2'h0
`define CWD_RESP_SLVERR 2'h2

`endif

// >>> rtl/cwd_word_decoder.v
// Combinational decode of the configuration word into its control fields.
`include "cwd_defines.vh"

module cwd_word_decoder (
    input wire [15:0] cfg_word,
    output reg [2:0] processor_mode_select,
    output reg code_protect,
    output reg [1:0] watchdog_postscale_select,
    output reg watchdog_enable,
    output reg timer16_only,
    output reg [8:0] watchdog_divide,
    output reg [1:0] oscillator_type_select,
    output reg [3:0] osc_onehot,
    output reg [15:0] readback
);

    // ======================================================================
    // Field extraction and decode
    // ======================================================================
    // Unlisted mode codes fall back to the protected mode, the safe choice.
    always @* begin
        processor_mode_select = {cfg_word[`CWD_BIT_MODE2], cfg_word[`CWD_BIT_MODE1],
                                 cfg_word[`CWD_BIT_MODE0]};
        case (processor_mode_select)
            `CWD_MODE_CPU: code_protect = 1'b0;
            `CWD_MODE_MCU: code_protect = 1'b0;
            `CWD_MODE_EXT: code_protect = 1'b0;
            `CWD_MODE_PROT: code_protect = 1'b1;
            default: code_protect = 1'b1;
        endcase
        watchdog_postscale_select = cfg_word[`CWD_PS_HI:`CWD_PS_LO];
        case (watchdog_postscale_select)
            `CWD_PS_DIV1: watchdog_divide = `CWD_DIV_ONE;
            `CWD_PS_DIV256: watchdog_divide = `CWD_DIV_256;
            `CWD_PS_DIV64: watchdog_divide = `CWD_DIV_64;
            default: watchdog_divide = `CWD_DIV_NONE;
        endcase
        watchdog_enable = (watchdog_postscale_select != `CWD_PS_OFF);
        timer16_only = (watchdog_postscale_select == `CWD_PS_OFF);
        oscillator_type_select = cfg_word[`CWD_OSC_HI:`CWD_OSC_LO];
        case (oscillator_type_select)
            `CWD_OSC_EXT: osc_onehot = 4'h8;
            `CWD_OSC_XTAL: osc_onehot = 4'h4;
            `CWD_OSC_RC: osc_onehot = 4'h2;
            default: osc_onehot = 4'h1;
        endcase
        // Bits 14-9 read as one; bits 7 and 5 always read as zero.
        readback = cfg_word | `CWD_UNIMPL_ONES;
        readback[`CWD_BIT_ZERO_HI] = 1'b0;
        readback[`CWD_BIT_ZERO_LO] = 1'b0;
    end

endmodule // cwd_word_decoder

// >>> rtl/cwd_top.v
// Configuration word holder and decoder with an AXI4-Lite register slave.
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`include "cwd_defines.vh"

module cwd_top (
    input wire aclk,
    input wire aresetn,
    input wire [31:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg mode_microprocessor,
    output reg mode_microcontroller,
    output reg mode_extended,
    output reg code_protect,
    output reg watchdog_enable,
    output reg timer16_only,
    output reg [8:0] watchdog_divide,
    output reg external_clock_input,
    output reg crystal_resonator,
    output reg resistor_capacitor_osc,
    output reg low_frequency_crystal
);

    // ======================================================================
    // State
    // ======================================================================
    reg [15:0] cfg_word_reg;
    reg [`CWD_ADDR_BITS-1:0] aw_addr_reg;
    reg aw_full_reg;
    reg [15:0] w_data_reg;
    reg [1:0] w_strb_reg;
    reg w_full_reg;
    reg [15:0] cfg_word_next;
    reg [31:0] rd_data_next;
    reg [1:0] rd_resp_next;
    reg [1:0] wr_resp_next;
    wire [2:0] dec_mode;
    wire dec_protect;
    wire dec_wdt_en;
    wire dec_tmr16;
    wire [8:0] dec_div;
    wire [1:0] dec_osc;
    wire [3:0] dec_osc_onehot;
    wire [15:0] dec_readback;
    wire [31:0] status_word;
    wire aw_take;
    wire w_take;
    wire wr_fire;
    wire ar_take;

    // ======================================================================
    // Field decoder
    // ======================================================================
    cwd_word_decoder u_dec (
        .cfg_word(cfg_word_reg),
        .processor_mode_select(dec_mode),
        .code_protect(dec_protect),
        .watchdog_postscale_select(),
        .watchdog_enable(dec_wdt_en),
        .timer16_only(dec_tmr16),
        .watchdog_divide(dec_div),
        .oscillator_type_select(dec_osc),
        .osc_onehot(dec_osc_onehot),
        .readback(dec_readback)
    );

    // Status word collects the decoded fields so software can confirm them.
    assign status_word = {7'h00, dec_div, 8'h00, dec_osc, dec_tmr16, dec_wdt_en,
                          dec_protect, dec_mode};

    // ======================================================================
    // Handshake terms
    // ======================================================================
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign wr_fire = aw_full_reg & w_full_reg & ~s_axi_bvalid;
    assign ar_take = s_axi_arvalid & s_axi_arready;

    // ======================================================================
    // Write decode
    // ======================================================================
    // Byte lanes above the 16-bit word are accepted and ignored.
    always @* begin
        cfg_word_next = cfg_word_reg;
        wr_resp_next = `CWD_RESP_OKAY;
        if (aw_addr_reg == `CWD_ADDR_CONFIG) begin
            if (w_strb_reg[0]) begin
                cfg_word_next[7:0] = w_data_reg[7:0];
            end
            if (w_strb_reg[1]) begin
                cfg_word_next[15:8] = w_data_reg[15:8];
            end
        end else if (aw_addr_reg == `CWD_ADDR_STATUS) begin
            wr_resp_next = `CWD_RESP_OKAY; // Read-only: write is dropped.
        end else begin
            wr_resp_next = `CWD_RESP_SLVERR;
        end
    end

    // ======================================================================
    // Read decode
    // ======================================================================
    always @* begin
        rd_data_next = 32'h0000_0000;
        rd_resp_next = `CWD_RESP_OKAY;
        case (s_axi_araddr[`CWD_ADDR_BITS-1:0])
            `CWD_ADDR_CONFIG: rd_data_next = {16'h0000, dec_readback};
            `CWD_ADDR_STATUS: rd_data_next = status_word;
            default: rd_resp_next = `CWD_RESP_SLVERR;
        endcase
        if (s_axi_araddr[31:`CWD_ADDR_BITS] != 28'h000_0000) begin
            rd_resp_next = `CWD_RESP_SLVERR;
            rd_data_next = 32'h0000_0000;
        end
    end

    // ======================================================================
    // Write channel: address and data are caught in either order
    // ======================================================================
    // Each ready drops after its beat and returns only when the response is
    // taken, so at most one write is ever in flight.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CWD_RESP_OKAY;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_data_reg <= 16'h0000;
            w_strb_reg <= 2'h0;
            cfg_word_reg <= `CWD_CFG_RESET;
        end else begin
            if (aw_take) begin
                s_axi_awready <= 1'b0;
                aw_full_reg <= 1'b1;
                // High address bits out of range turn into an unmapped index.
                if (s_axi_awaddr[31:`CWD_ADDR_BITS] != 28'h000_0000) begin
                    aw_addr_reg <= 4'hf;
                end else begin
                    aw_addr_reg <= s_axi_awaddr[`CWD_ADDR_BITS-1:0];
                end
            end
            if (w_take) begin
                s_axi_wready <= 1'b0;
                w_full_reg <= 1'b1;
                // Only the two lanes of the 16-bit word are kept.
                w_data_reg <= s_axi_wdata[15:0];
                w_strb_reg <= s_axi_wstrb[1:0];
            end
            if (wr_fire) begin
                cfg_word_reg <= cfg_word_next;
                s_axi_bresp <= wr_resp_next;
                s_axi_bvalid <= 1'b1;
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ======================================================================
    // Read channel
    // ======================================================================
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CWD_RESP_OKAY;
        end else begin
            if (ar_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_data_next;
                s_axi_rresp <= rd_resp_next;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ======================================================================
    // Decoded control outputs
    // ======================================================================
    // Registered so every output comes from a flop; they follow a new word
    // one cycle after the write lands, and the core treats them as static.
    always @(posedge aclk) begin
        if (!aresetn) begin
            mode_microprocessor <= 1'b0;
            mode_microcontroller <= 1'b0;
            mode_extended <= 1'b0;
            code_protect <= 1'b1;
            watchdog_enable <= 1'b0;
            timer16_only <= 1'b0;
            watchdog_divide <= `CWD_DIV_NONE;
            external_clock_input <= 1'b0;
            crystal_resonator <= 1'b0;
            resistor_capacitor_osc <= 1'b0;
            low_frequency_crystal <= 1'b0;
        end else begin
            mode_microprocessor <= (dec_mode == `CWD_MODE_CPU);
            mode_microcontroller <= (dec_mode == `CWD_MODE_MCU);
            mode_extended <= (dec_mode == `CWD_MODE_EXT);
            code_protect <= dec_protect;
            watchdog_enable <= dec_wdt_en;
            timer16_only <= dec_tmr16;
            watchdog_divide <= dec_div;
            external_clock_input <= dec_osc_onehot[3];
            crystal_resonator <= dec_osc_onehot[2];
            resistor_capacitor_osc <= dec_osc_onehot[1];
            low_frequency_crystal <= dec_osc_onehot[0];
        end
    end

endmodule // cwd_top

// >>> sim/cwd_monitor.sv
// Concurrent assertions on the ports of the configuration word decoder top.
module cwd_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic mode_microprocessor,
    input wire logic mode_microcontroller,
    input wire logic mode_extended,
    input wire logic code_protect,
    input wire logic watchdog_enable,
    input wire logic timer16_only,
    input wire logic [8:0] watchdog_divide,
    input wire logic external_clock_input,
    input wire logic crystal_resonator,
    input wire logic resistor_capacitor_osc,
    input wire logic low_frequency_crystal
);
    timeunit 1ns;
    timeprecision 1ps;

    // ======================================================================
    // Settling helper
    // ======================================================================
    logic [1:0] up_cnt;
    logic settled;
    logic [3:0] mode_bits;
    logic [3:0] osc_bits;

    // Outputs reload one edge after reset ends, so relations wait three edges.
    always @(posedge aclk) begin
        if (!aresetn) up_cnt <= 2'h0;
        else if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
    end

    // Bundles of the one-hot decode groups.
    assign settled = (up_cnt == 2'h3);
    assign mode_bits = {mode_microprocessor, mode_microcontroller, mode_extended, code_protect};
    assign osc_bits = {external_clock_input, crystal_resonator, resistor_capacitor_osc,
                       low_frequency_crystal};

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ======================================================================
    // Sequences and assertions
    // ======================================================================
    sequence rd_cfg;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 32'h0;
    endsequence
    sequence rd_hold;
        s_axi_rvalid && !s_axi_rready;
    endsequence

    a_mode_onehot: assert property (settled |-> $onehot(mode_bits))
        else $error("mode outputs not one-hot");
    a_osc_onehot: assert property (settled |-> $onehot(osc_bits))
        else $error("oscillator outputs not one-hot");
    a_wdt_exclusive: assert property (settled |-> watchdog_enable != timer16_only)
        else $error("watchdog enable and timer mode overlap");
    a_div_enable: assert property (settled |->
        (watchdog_enable == (watchdog_divide != 9'h000))
        && watchdog_divide inside {9'h000, 9'h001, 9'h040, 9'h100})
        else $error("watchdog divide illegal");
    a_decode_stable: assert property (settled && !s_axi_bvalid && !$past(s_axi_bvalid)
        |-> $stable({mode_bits, osc_bits, watchdog_enable, timer16_only, watchdog_divide}))
        else $error("decoded outputs moved without a write");
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rdata_hold: assert property (rd_hold |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped while stalled");
    a_cfg_zero_bits: assert property (rd_cfg |=> !s_axi_rdata[7] && !s_axi_rdata[5])
        else $error("unimplemented bits read nonzero");
endmodule // cwd_monitor

bind cwd_top cwd_monitor u_mon (.aclk, .aresetn, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .mode_microprocessor, .mode_microcontroller, .mode_extended, .code_protect,
    .watchdog_enable, .timer16_only, .watchdog_divide, .external_clock_input,
    .crystal_resonator, .resistor_capacitor_osc, .low_frequency_crystal);

// >>> sim/tb.sv
// Self-checking testbench for the configuration word decoder top.
`include "cwd_defines.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [15:0] cfg;
        logic [15:0] rb;
        logic [18:0] outs;
    } cwd_row_t;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, st;
    logic [3:0] s_axi_wstrb;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic mode_microprocessor, mode_microcontroller, mode_extended, code_protect;
    logic watchdog_enable, timer16_only, external_clock_input, crystal_resonator;
    logic resistor_capacitor_osc, low_frequency_crystal;
    logic [8:0] watchdog_divide;
    logic [18:0] dec;
    int errors, samples_checked;
    // Word written, its readback, and the decoded outputs it should give.
    cwd_row_t rows [5] = '{'{16'h805f, 16'hfe5f, 19'h44018}, '{16'h804a, 16'hfe4a, 19'h25004},
        '{16'h8015, 16'hfe15, 19'h14402}, '{16'h7fa0, 16'h7f00, 19'h0a001},
        '{16'h8000, 16'hfe00, 19'h0a001}};

    cwd_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mode_microprocessor,
        .mode_microcontroller, .mode_extended, .code_protect, .watchdog_enable, .timer16_only,
        .watchdog_divide, .external_clock_input, .crystal_resonator, .resistor_capacitor_osc,
        .low_frequency_crystal);

    // Decoded outputs packed in the same order as the table column.
    assign dec = {mode_microprocessor, mode_microcontroller, mode_extended, code_protect,
        watchdog_enable, timer16_only, watchdog_divide, external_clock_input,
        crystal_resonator, resistor_capacitor_osc, low_frequency_crystal};

    // ======================================================================
    // Tasks
    // ======================================================================
    task automatic check(input string name, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Address and data go out together; each is dropped once its ready is seen.
    task automatic axi_write(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        check("bresp", s_axi_bresp, er);
        s_axi_bready <= 1'b0;
    endtask

    // A nonzero stall keeps rready low for that many cycles of valid data.
    task automatic axi_read(input logic [31:0] a, input int stall, input logic [31:0] ed,
                            input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= (stall == 0);
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1 && s_axi_rready !== 1'b1) begin
                stall--;
                if (stall <= 0) s_axi_rready <= 1'b1;
            end
        end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1));
        check("rdata", s_axi_rdata, ed);
        check("rresp", s_axi_rresp, er);
        s_axi_rready <= 1'b0;
    endtask

    // ======================================================================
    // Clock, watchdog and main sequence
    // ======================================================================
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // A run of under two hundred cycles is expected; far beyond that is a hang.
    initial begin
        repeat (5000) @(posedge aclk);
        errors++;
        $display("[ERR] watchdog expired");
        stop_test();
    end

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb, s_axi_awprot, s_axi_arprot} <= '0;
        repeat (20) @(posedge aclk);
        check("reset_outs", dec, 19'h08000);
        check("reset_bus", {s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid,
            s_axi_rvalid}, 5'b11100);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        check("erased_outs", dec, 19'h44018);
        axi_read(32'h0, 0, 32'hff5f, `CWD_RESP_OKAY);
        $display("test reset done");
        // Table rows cover every listed mode plus unlisted mode code 4, and every postscale and oscillator code.
        foreach (rows[i]) begin
            st = {7'h0, rows[i].outs[12:4], 8'h0, rows[i].cfg[1:0], rows[i].outs[13],
                rows[i].outs[14], rows[i].outs[15], rows[i].cfg[15], rows[i].cfg[6],
                rows[i].cfg[4]};
            axi_write(32'h0, {16'h0, rows[i].cfg}, 4'hf, `CWD_RESP_OKAY);
            repeat (2) @(posedge aclk);
            check("decoded", dec, rows[i].outs);
            axi_read(32'h0, 0, {16'h0, rows[i].rb}, `CWD_RESP_OKAY);
            axi_read(32'h4, i, st, `CWD_RESP_OKAY);
            $display("test row %0d done", i);
        end
        // Low byte only: the mode bit in the upper byte must survive.
        axi_write(32'h0, 32'h0000ff0f, 4'b0001, `CWD_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("strobe_outs", dec, 19'h0c018);
        axi_write(32'h4, 32'h0, 4'hf, `CWD_RESP_OKAY);
        axi_write(32'h8, 32'h0, 4'hf, `CWD_RESP_SLVERR);
        axi_read(32'h8, 0, 32'h0, `CWD_RESP_SLVERR);
        axi_read(32'h1, 0, 32'h0, `CWD_RESP_SLVERR);
        axi_read(32'h0, 2, 32'hfe0f, `CWD_RESP_OKAY);
        $display("test strobe and unmapped done");
        // Back-to-back writes, then a reset in mid-run restores the erased word.
        axi_write(32'h0, 32'h8015, 4'hf, `CWD_RESP_OKAY);
        axi_write(32'h0, 32'h804a, 4'hf, `CWD_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("b2b_outs", dec, 19'h25004);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        check("rerst_outs", dec, 19'h44018);
        axi_read(32'h0, 0, 32'hff5f, `CWD_RESP_OKAY);
        $display("test back-to-back and reset done");
        stop_test();
    end
endmodule // tb
